/* inc/ufci_params.svh */
`ifndef UFCI_PARAMS_SVH
`define UFCI_PARAMS_SVH

// Register word indices (byte address is four times the index)
`define UFCI_IDX_ENABLE 4'h1
`define UFCI_IDX_FIFO 4'h2
`define UFCI_IDX_PORT 4'h4
`define UFCI_IDX_EVTSTAT 4'h5
`define UFCI_IDX_EVTMASK 4'h6

// fifo_control fields
`define UFCI_FC_ENABLE 0
`define UFCI_FC_RXCLR 1
`define UFCI_FC_TXCLR 2
`define UFCI_FC_TRIG_LO 6
`define UFCI_FC_TRIG_HI 7

// interrupt_enable fields
`define UFCI_IE_RDA 0
`define UFCI_IE_THRE 1
`define UFCI_IE_RLS 2
`define UFCI_IE_MS 3

// Port control field
`define UFCI_PC_USER_OUTPUT_TWO 3

// Event status bit positions
`define UFCI_EV_RLS 0
`define UFCI_EV_RDA 1
`define UFCI_EV_TO 2
`define UFCI_EV_THRE 3
`define UFCI_EV_MS 4

// Identification codes, bits 3:0; FIFO mode code for bits 7:6
`define UFCI_ID_NONE 4'h1
`define UFCI_ID_RLS 4'h6
`define UFCI_ID_RDA 4'h4
`define UFCI_ID_TO 4'hC
`define UFCI_ID_THRE 4'h2
`define UFCI_ID_MS 4'h0
`define UFCI_ID_FIFO_ON 2'h3

// Trigger levels in bytes
`define UFCI_TRIG_1 8'h01
`define UFCI_TRIG_4 8'h04
`define UFCI_TRIG_8 8'h08
`define UFCI_TRIG_14 8'h0E

// Character times of silence before a timeout
`define UFCI_TIMEOUT_CHARS 3'h4

// Reset values
`define UFCI_RST_TRIG 2'h0
`define UFCI_RST_ENABLE 4'h0
`define UFCI_RST_EVT 5'h00

`endif

/* inc/ufci_pkg.sv */
package ufci_pkg;
    typedef logic [31:0] ufci_word_t;
    typedef logic [7:0] ufci_byte_t;
    typedef logic [4:0] ufci_evt_t;
    typedef enum logic {
        BUS_IDLE,
        BUS_DONE
    } ufci_bus_t;
endpackage : ufci_pkg

/* inc/ufci_rx_if.sv */
interface ufci_rx_if;
    logic fifoMode;
    logic rxPush;
    logic rxPop;
    logic rxFlush;
    logic rxEmpty;
    logic charTick;
    logic timeout;
    modport ctl (
        output fifoMode, rxPush, rxPop, rxFlush, rxEmpty, charTick,
        input timeout
    );
    modport tmr (
        input fifoMode, rxPush, rxPop, rxFlush, rxEmpty, charTick,
        output timeout
    );
endinterface : ufci_rx_if

/* rtl/ufci_timeout.sv */
`include "ufci_params.svh"

module ufci_timeout (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Receive FIFO activity
    ufci_rx_if.tmr rx
);
    import ufci_pkg::*;

    logic [2:0] ticks_q;
    logic timeout_q;
    logic restart;

    // Any FIFO activity or an empty FIFO restarts the silence count
    assign restart = !rx.fifoMode || rx.rxEmpty || rx.rxPush ||
        rx.rxPop || rx.rxFlush;

    always_ff @(posedge sys_clk) begin
        if (rst || restart) begin
            ticks_q <= 3'h0;
        end else if (rx.charTick && ticks_q != `UFCI_TIMEOUT_CHARS) begin
            ticks_q <= ticks_q + 3'h1; // [R15]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timeout_q <= 1'b0;
        end else if (rx.rxPop || rx.rxFlush || !rx.fifoMode ||
            rx.rxEmpty) begin
            timeout_q <= 1'b0; // [R16]
        end else if (ticks_q == `UFCI_TIMEOUT_CHARS) begin
            timeout_q <= 1'b1; // [R15]
        end
    end

    assign rx.timeout = timeout_q;
endmodule : ufci_timeout

/* rtl/ufci_top.sv */
// Function
// R1: fifo_control bit 0 one enables both FIFOs; zero disables and empties them.
// R2: Leaving FIFO operation empties both FIFOs automatically.
// R3: Host keeps bit 0 set when programming the other control bits.
// R4: Bit 1 flushes receive FIFO and counters, not shift register; self-clears.
// R5: Bit 2 flushes transmit FIFO and counters, not shift register; self-clears.
// R6: Bit 3 does nothing; no DMA; bits 4 and 5 reserved.
// R7: Bits 7:6 pick receive trigger level of 1, 4, 8 or 14 bytes.
// R8: Priority: line status, received data or timeout, transmit empty, modem.
// R9: Identification value stays frozen during a host read of it.
// R10: Ident bit 0 reads zero while an enabled interrupt is pending.
// R11: Ident bits 3:0 encode highest pending source with fixed codes.
// R12: Ident bit 3 is zero outside FIFO mode, set with timeout.
// R13: Ident bits 4 and 5 always read zero.
// R14: Ident bits 7:6 read one while FIFO enable is one.
// R15: Timeout after four silent character times with data in receive FIFO.
// R16: Each source clears on its own read or write event.
// R17: A source is reported only while its interrupt_enable bit is set.
// R18: Interrupt pin is driven only while user_output_two is one.
// R19: Reset leaves FIFOs off and empty, trigger one byte, ident 0x01.
//
// Added by the designer: the Avalon-MM register port.
`include "ufci_params.svh"

module ufci_top #(
    parameter int CNT_W = 5
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire ufci_pkg::ufci_word_t writedata,
    output ufci_pkg::ufci_word_t readdata,
    output logic waitrequest,
    // Receive FIFO status and strobes
    input wire logic [CNT_W-1:0] rxCount,
    input wire logic rxPush,
    input wire logic rxPop,
    input wire logic charTick,
    // Transmitter, line and modem status strobes
    input wire logic thrEmptyEvt,
    input wire logic thrWrite,
    input wire logic lineErr,
    input wire logic lsrRead,
    input wire logic modemChange,
    input wire logic msrRead,
    // FIFO control outputs
    output logic fifoEnable,
    output logic rxFlush,
    output logic txFlush,
    output logic [CNT_W-1:0] triggerLevel,
    // Interrupt outputs
    output logic intrOut,
    output logic intrOe,
    output logic irq
);
    import ufci_pkg::*;

    // Receive trigger level in bytes from the two select bits
    function automatic logic [CNT_W-1:0] trigBytes(input logic [1:0] sel);
        logic [7:0] bytes;
        case (sel)
            2'h0: bytes = `UFCI_TRIG_1;
            2'h1: bytes = `UFCI_TRIG_4;
            2'h2: bytes = `UFCI_TRIG_8;
            default: bytes = `UFCI_TRIG_14;
        endcase
        trigBytes = bytes[CNT_W-1:0];
    endfunction : trigBytes

    // Prioritised identification byte
    function automatic ufci_byte_t identByte(
        input logic fifoOn,
        input logic rls,
        input logic rda,
        input logic tmo,
        input logic thre,
        input logic ms
    );
        logic [3:0] code;
        if (rls) begin
            code = `UFCI_ID_RLS; // [R8] [R11]
        end else if (rda) begin
            code = `UFCI_ID_RDA;
        end else if (tmo) begin
            code = `UFCI_ID_TO; // [R12]
        end else if (thre) begin
            code = `UFCI_ID_THRE;
        end else if (ms) begin
            code = `UFCI_ID_MS;
        end else begin
            code = `UFCI_ID_NONE; // [R10]
        end
        identByte = {fifoOn ? `UFCI_ID_FIFO_ON : 2'h0, 2'h0, code};
    endfunction : identByte // [R13] [R14]

    // Completing access to one register index
    function automatic logic regHit(
        input logic done,
        input logic [3:0] idx,
        input logic [3:0] want
    );
        regHit = done && idx == want;
    endfunction : regHit

    ufci_rx_if rxIf ();

    ufci_bus_t busState_q;
    logic [3:0] regIdx;
    logic reqActive;
    logic wrDone;
    logic rdDone;
    logic fifoWrite;
    logic rdStart;
    logic [3:0] ienable_q;
    logic [1:0] trigSel_q;
    logic fifoEnable_q;
    logic rxFlush_q;
    logic txFlush_q;
    logic userOut2_q;
    logic rlsPend_q;
    logic threPend_q;
    logic msPend_q;
    logic rdaPend;
    logic rlsOn;
    logic rdaOn;
    logic toOn;
    logic threOn;
    logic msOn;
    ufci_byte_t identNow;
    ufci_byte_t identSnap_q;
    ufci_word_t readdata_q;
    ufci_evt_t evtNow;
    ufci_evt_t evtPrev_q;
    ufci_evt_t evtRise;
    ufci_evt_t evtStat_q;
    ufci_evt_t evtMask_q;
    logic intrOut_q;

    // Bus handshake: one wait state on every access
    assign reqActive = read || write;
    assign regIdx = address[5:2];
    assign waitrequest = reqActive && busState_q == BUS_IDLE;
    assign wrDone = write && busState_q == BUS_DONE;
    assign rdDone = read && busState_q == BUS_DONE;
    assign fifoWrite = regHit(wrDone, regIdx, `UFCI_IDX_FIFO);
    assign rdStart = read && busState_q == BUS_IDLE;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            busState_q <= BUS_IDLE;
        end else begin
            case (busState_q)
                BUS_IDLE: begin
                    if (reqActive) begin
                        busState_q <= BUS_DONE;
                    end
                end
                BUS_DONE: busState_q <= BUS_IDLE;
                default: busState_q <= BUS_IDLE;
            endcase
        end
    end

    // Interrupt enable and port control registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ienable_q <= `UFCI_RST_ENABLE;
        end else if (regHit(wrDone, regIdx, `UFCI_IDX_ENABLE)) begin
            ienable_q <= writedata[3:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            userOut2_q <= 1'b0;
        end else if (regHit(wrDone, regIdx, `UFCI_IDX_PORT)) begin
            userOut2_q <= writedata[`UFCI_PC_USER_OUTPUT_TWO];
        end
    end

    // FIFO control; bit 3 and bits 5:4 are ignored [R6]
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fifoEnable_q <= 1'b0; // [R19]
            trigSel_q <= `UFCI_RST_TRIG;
        end else if (fifoWrite) begin
            fifoEnable_q <= writedata[`UFCI_FC_ENABLE]; // [R1]
            if (writedata[`UFCI_FC_ENABLE]) begin
                trigSel_q <= writedata[`UFCI_FC_TRIG_HI:`UFCI_FC_TRIG_LO]; // [R7] [R3]
            end
        end
    end

    // Flush strobes last one cycle, so the bits clear themselves
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rxFlush_q <= 1'b1; // [R19]
            txFlush_q <= 1'b1;
        end else begin
            rxFlush_q <= fifoWrite && (!writedata[`UFCI_FC_ENABLE] ||
                writedata[`UFCI_FC_RXCLR]); // [R1] [R2] [R4]
            txFlush_q <= fifoWrite && (!writedata[`UFCI_FC_ENABLE] ||
                writedata[`UFCI_FC_TXCLR]); // [R1] [R2] [R5]
        end
    end

    // Character timeout detection
    assign rxIf.fifoMode = fifoEnable_q;
    assign rxIf.rxPush = rxPush;
    assign rxIf.rxPop = rxPop;
    assign rxIf.rxFlush = rxFlush_q;
    assign rxIf.rxEmpty = rxCount == '0;
    assign rxIf.charTick = charTick;

    ufci_timeout timeoutUnit (
        .sys_clk(sys_clk),
        .rst(rst),
        .rx(rxIf.tmr)
    );

    // Pending sources; a new event wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rlsPend_q <= 1'b0;
        end else if (lineErr) begin
            rlsPend_q <= 1'b1;
        end else if (lsrRead) begin
            rlsPend_q <= 1'b0; // [R16]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            threPend_q <= 1'b0;
        end else if (thrEmptyEvt) begin
            threPend_q <= 1'b1;
        end else if (thrWrite || (regHit(rdDone, regIdx, `UFCI_IDX_FIFO) &&
            identSnap_q[3:0] == `UFCI_ID_THRE)) begin
            threPend_q <= 1'b0; // [R16]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            msPend_q <= 1'b0;
        end else if (modemChange) begin
            msPend_q <= 1'b1;
        end else if (msrRead) begin
            msPend_q <= 1'b0; // [R16]
        end
    end

    // Data available follows the FIFO level; clears below trigger in FIFO mode, when empty otherwise
    assign rdaPend = fifoEnable_q ? rxCount >= triggerLevel :
        rxCount != '0; // [R16]

    assign rlsOn = rlsPend_q && ienable_q[`UFCI_IE_RLS]; // [R17]
    assign rdaOn = rdaPend && ienable_q[`UFCI_IE_RDA]; // [R17]
    assign toOn = rxIf.timeout && ienable_q[`UFCI_IE_RDA]; // [R17]
    assign threOn = threPend_q && ienable_q[`UFCI_IE_THRE]; // [R17]
    assign msOn = msPend_q && ienable_q[`UFCI_IE_MS]; // [R17]

    assign identNow = identByte(fifoEnable_q, rlsOn, rdaOn, toOn,
        threOn, msOn);

    // Snapshot taken when the read begins and held until it completes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            identSnap_q <= identByte(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        end else if (rdStart) begin
            identSnap_q <= identNow; // [R9]
        end
    end

    // Read data is latched in the wait cycle and stands at completion
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            readdata_q <= '0;
        end else if (rdStart) begin
            case (regIdx)
                `UFCI_IDX_ENABLE: readdata_q <= {28'h0, ienable_q};
                `UFCI_IDX_FIFO: readdata_q <= {24'h0, identNow}; // [R9]
                `UFCI_IDX_PORT: readdata_q <= {28'h0, userOut2_q, 3'h0};
                `UFCI_IDX_EVTSTAT: readdata_q <= {27'h0, evtStat_q};
                `UFCI_IDX_EVTMASK: readdata_q <= {27'h0, evtMask_q};
                default: readdata_q <= '0;
            endcase
        end
    end

    // Sticky event status, write one to clear; a new event wins
    assign evtNow = {msOn, threOn, toOn, rdaOn, rlsOn};
    assign evtRise = evtNow & ~evtPrev_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            evtPrev_q <= `UFCI_RST_EVT;
        end else begin
            evtPrev_q <= evtNow;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            evtStat_q <= `UFCI_RST_EVT;
        end else if (regHit(wrDone, regIdx, `UFCI_IDX_EVTSTAT)) begin
            evtStat_q <= (evtStat_q & ~writedata[4:0]) | evtRise;
        end else begin
            evtStat_q <= evtStat_q | evtRise;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            evtMask_q <= `UFCI_RST_EVT;
        end else if (regHit(wrDone, regIdx, `UFCI_IDX_EVTMASK)) begin
            evtMask_q <= writedata[4:0];
        end
    end

    // Port interrupt follows any enabled pending source
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            intrOut_q <= 1'b0;
        end else begin
            intrOut_q <= |evtNow; // [R10]
        end
    end

    assign readdata = readdata_q;
    assign fifoEnable = fifoEnable_q;
    assign rxFlush = rxFlush_q;
    assign txFlush = txFlush_q;
    assign triggerLevel = trigBytes(trigSel_q); // [R7]
    assign intrOut = intrOut_q;
    assign intrOe = userOut2_q; // [R18]
    assign irq = |(evtStat_q & evtMask_q);
endmodule : ufci_top

/* verification/ufci_top_monitor.sv */
module ufci_top_monitor #(
    parameter int CNT_W = 5
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Bus
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire ufci_pkg::ufci_word_t readdata,
    input wire logic waitrequest,
    // Control and interrupt
    input wire logic fifoEnable,
    input wire logic rxFlush,
    input wire logic txFlush,
    input wire logic [CNT_W-1:0] triggerLevel,
    input wire logic intrOut,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    import ufci_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // Completing edge of an ident read
    sequence identRd;
        read && !waitrequest && address[5:2] == 4'h2;
    endsequence

    wait_first_a: assert property ($rose(read) |-> waitrequest)
        else $error("read not stalled one cycle");
    wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("access took more than one wait state");
    rx_pulse_a: assert property (rxFlush |=> !rxFlush)
        else $error("receive flush longer than a cycle");
    tx_pulse_a: assert property (txFlush |=> !txFlush)
        else $error("transmit flush longer than a cycle");
    leave_flush_a: assert property ($fell(fifoEnable) |-> rxFlush && txFlush)
        else $error("leaving fifo mode did not flush");
    trig_legal_a: assert property (triggerLevel inside {5'h01, 5'h04, 5'h08, 5'h0E})
        else $error("illegal trigger level");
    ident_zero_a: assert property (identRd |-> readdata[5:4] == 2'h0 && readdata[31:8] == 24'h0)
        else $error("ident fixed bits not zero");
    ident_mode_a: assert property (identRd |-> readdata[7:6] == {2{fifoEnable}})
        else $error("ident mode bits wrong");
    ident_tmo_a: assert property (identRd ##0 readdata[3] |-> readdata[2] && fifoEnable && !readdata[0])
        else $error("timeout code outside fifo mode");
    reset_state_a: assert property ($fell(rst) |-> !fifoEnable && !intrOut && !irq && triggerLevel == 5'h01)
        else $error("wrong state after reset");
endmodule : ufci_top_monitor

/* verification/ufci_rx_model.sv */
module ufci_rx_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Bench requests
    input wire logic pushReq,
    input wire logic popReq,
    // Block side
    input wire logic rxFlush,
    output logic [4:0] rxCount,
    output logic rxPush,
    output logic rxPop,
    output logic charTick
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] count_q;
    logic [2:0] tickDiv_q;
    assign rxCount = count_q;
    assign rxPush = pushReq;
    assign rxPop = popReq && count_q != 5'h00;
    assign charTick = tickDiv_q == 3'h7;
    // Byte count of the receive store
    always_ff @(posedge sys_clk) begin
        if (rst || rxFlush) begin
            count_q <= 5'h00;
        end else begin
            count_q <= count_q + {4'h0, rxPush} - {4'h0, rxPop};
        end
    end
    // Character time, free running
    always_ff @(posedge sys_clk) begin
        tickDiv_q <= rst ? 3'h0 : tickDiv_q + 3'h1;
    end
endmodule : ufci_rx_model

/* verification/test_uart_fifo_ctrl_int_ident.sv */
`include "ufci_params.svh"
module test_uart_fifo_ctrl_int_ident;
    timeunit 1ns;
    timeprecision 1ps;
    import ufci_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] address = 6'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    ufci_word_t writedata = 32'h0;
    ufci_word_t readdata, rdat;
    logic waitrequest, fifoEnable, rxFlush, txFlush, intrOut, intrOe, irq;
    logic [4:0] rxCount, triggerLevel;
    logic rxPush, rxPop, charTick;
    logic [7:0] strb = 8'h00;
    logic [7:0] steps [8] = '{8'h40, 8'h04, 8'h01, 8'h10, 8'h20, 8'h06,
        8'h00, 8'h80};
    logic [7:0] ids [8] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h04, 8'h02,
        8'h00, 8'h01};
    logic [31:0] trig [4] = '{32'h1, 32'h4, 32'h8, 32'hE};
    int bad_count = 0;
    int compares = 0;
    int n;

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    ufci_top #(.CNT_W(5)) dut (
        .sys_clk(sys_clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .rxCount(rxCount), .rxPush(rxPush),
        .rxPop(rxPop), .charTick(charTick), .thrEmptyEvt(strb[2]),
        .thrWrite(strb[3]), .lineErr(strb[4]), .lsrRead(strb[5]),
        .modemChange(strb[6]), .msrRead(strb[7]),
        .fifoEnable(fifoEnable), .rxFlush(rxFlush), .txFlush(txFlush),
        .triggerLevel(triggerLevel), .intrOut(intrOut), .intrOe(intrOe),
        .irq(irq)
    );
    ufci_rx_model far (
        .sys_clk(sys_clk), .rst(rst), .pushReq(strb[0]), .popReq(strb[1]),
        .rxFlush(rxFlush), .rxCount(rxCount), .rxPush(rxPush),
        .rxPop(rxPop), .charTick(charTick)
    );

    task automatic close_out;
        $display("Compares %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [3:0] idx,
            input logic [31:0] d);
        logic busy;
        int k;
        busy = 1'b1;
        k = 0;
        @(posedge sys_clk);
        address <= {idx, 2'b00};
        read <= !wr;
        write <= wr;
        writedata <= d;
        while (busy) begin
            @(posedge sys_clk);
            busy = waitrequest !== 1'b0;
            rdat = readdata;
            k++;
            if (k > 20) begin
                bad_count++;
                close_out();
            end
        end
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic ident(input logic [7:0] e);
        bus(1'b0, `UFCI_IDX_FIFO, 32'h0);
        chk("ident", rdat, {24'h0, e});
    endtask : ident

    task automatic fc(input logic [7:0] d, input logic [1:0] f);
        bus(1'b1, `UFCI_IDX_FIFO, {24'h0, d});
        @(negedge sys_clk);
        chk("flush", {30'h0, rxFlush, txFlush}, {30'h0, f});
        chk("enable", {31'h0, fifoEnable}, {31'h0, d[0]});
    endtask : fc

    task automatic pulse(input logic [7:0] v);
        @(posedge sys_clk);
        strb <= v;
        @(posedge sys_clk);
        strb <= 8'h00;
    endtask : pulse

    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        ident(8'h01);
        chk("trigger", 32'(triggerLevel), 32'h1);
        $display("Reset test done");
        for (int i = 0; i < 4; i++) begin
            fc({i[1:0], 6'h39}, 2'h0);
            chk("trigger", 32'(triggerLevel), trig[i]);
            ident(8'hC1);
        end
        fc(8'h03, 2'h2);
        fc(8'h05, 2'h1);
        fc(8'h00, 2'h3);
        ident(8'h01);
        $display("Fifo control test done");
        bus(1'b1, `UFCI_IDX_ENABLE, 32'hF);
        bus(1'b1, `UFCI_IDX_PORT, 32'h8);
        bus(1'b1, `UFCI_IDX_EVTMASK, 32'h1F);
        chk("intrOe", 32'(intrOe), 32'h1);
        for (int i = 0; i < 8; i++) begin
            pulse(steps[i]);
            ident(ids[i]);
            if (i == 3) begin
                chk("intrOut", 32'({intrOut, irq}), 32'h3);
                bus(1'b0, `UFCI_IDX_EVTSTAT, 32'h0);
                chk("events", rdat, 32'h1B);
                bus(1'b1, `UFCI_IDX_EVTSTAT, 32'h1F);
                @(negedge sys_clk);
                chk("irq", 32'(irq), 32'h0);
            end
        end
        pulse(8'h04);
        pulse(8'h08);
        ident(8'h01);
        chk("intrOut", 32'(intrOut), 32'h0);
        $display("Priority test done");
        fc(8'hC1, 2'h0);
        pulse(8'h01);
        n = 0;
        rdat = 32'h0;
        while (rdat !== 32'hCC && n < 30) begin
            bus(1'b0, `UFCI_IDX_FIFO, 32'h0);
            n++;
        end
        chk("timeout", rdat, 32'hCC);
        pulse(8'h02);
        ident(8'hC1);
        $display("Timeout test done");
        bus(1'b1, `UFCI_IDX_ENABLE, 32'h0);
        pulse(8'h10);
        ident(8'hC1);
        chk("intrOut", 32'(intrOut), 32'h0);
        bus(1'b0, 4'h0, 32'h0);
        chk("unmapped", rdat, 32'h0);
        fc(8'h00, 2'h3);
        ident(8'h01);
        $display("Enable test done");
        close_out();
    end
endmodule : test_uart_fifo_ctrl_int_ident

bind ufci_top ufci_top_monitor #(.CNT_W(CNT_W)) mon (
    .sys_clk(sys_clk), .rst(rst), .address(address), .read(read),
    .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .fifoEnable(fifoEnable), .rxFlush(rxFlush), .txFlush(txFlush),
    .triggerLevel(triggerLevel), .intrOut(intrOut), .irq(irq)
);
